/* src/occ_channel6.sv */
// Purpose: Channel 6 clock output control: source mux, output divider,
//          driver format and leg decode, register file.
// Assumes: Source clocks are far slower than core_clk_i; they are
//          sampled, so the output is a rebuilt clock at core resolution.
// Notes:   ce_i low freezes every flop.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "occ_consts.svh"

// Summary of operation
// - Source field picks synth1, synth2, primary, secondary
// - Format field: off, AC diff, HCSL, CMOS
// - CMOS positive leg: tristate, low, inverted, true
// - Diff tail current 4/6/8, code3 16 or 8
// - Mode2: HCSL load, or CMOS negative leg
// - Divider ratio equals code plus one
// - Divider only on synthesizer sources
module occ_channel6 (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Source clocks from outside the core domain
	input wire logic [3:0] src_clk_i,
	// Nonvolatile start-up image
	input wire logic nvm_load_i,
	input wire logic [7:0] nvm_ctl_i,
	input wire logic [7:0] nvm_div_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Output pins
	output logic out_p_o,
	output logic out_p_oe_o,
	output logic out_n_o,
	output logic out_n_oe_o,
	// Analog driver settings
	output logic [4:0] tail_ma_o,
	output logic [7:0] load_ohm_o
);

	occ_pkg::occ_ctl_s ctl_r;
	logic [7:0] div_r;
	logic nvm_done_r;
	logic [2:0] sync_r [4];
	logic lvl_r;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic clk_r;
	logic sel_agree;
	logic sel_s3;
	logic rise;
	logic bypass;
	logic [8:0] half;
	occ_pkg::occ_leg_s leg_p;
	occ_pkg::occ_leg_s leg_n;

	// ============================================================
	// Register file
	// Software wins over the start-up image in the same cycle.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ctl_r <= occ_pkg::occ_ctl_s'({`OCC_RST_SRC, `OCC_RST_FMT,
				`OCC_RST_M1, `OCC_RST_M2});
		end else if (ce_i) begin
			if (wr_i && addr_i == `OCC_OFF_CTL) begin
				ctl_r <= occ_pkg::occ_ctl_s'(wdata_i);
			end else if (nvm_load_i && !nvm_done_r) begin
				ctl_r <= occ_pkg::occ_ctl_s'(nvm_ctl_i);
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			div_r <= `OCC_RST_DIV;
		end else if (ce_i) begin
			if (wr_i && addr_i == `OCC_OFF_DIV) begin
				div_r <= wdata_i;
			end else if (nvm_load_i && !nvm_done_r) begin
				div_r <= nvm_div_i;
			end
		end
	end

	// Only the first image after reset is taken
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			nvm_done_r <= 1'b0;
		end else if (ce_i && nvm_load_i) begin
			nvm_done_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (!rd_i) begin
				rdata_o <= 8'h00;
			end else if (addr_i == `OCC_OFF_CTL) begin
				rdata_o <= ctl_r;
			end else if (addr_i == `OCC_OFF_DIV) begin
				rdata_o <= div_r;
			end else if (addr_i == `OCC_OFF_STAT) begin
				rdata_o <= {5'h00, clk_r, !bypass, nvm_done_r};
			end else begin
				rdata_o <= 8'h00;
			end
		end
	end

	// ============================================================
	// Source synchronisers, all four kept running so a mux change
	// needs no resettling of the chosen source.
	for (genvar g = 0; g < 4; g++) begin : g_sync
		always_ff @(posedge core_clk_i) begin
			if (!rstn_i) begin
				sync_r[g] <= 3'h0;
			end else if (ce_i) begin
				sync_r[g] <= {sync_r[g][1:0], src_clk_i[g]};
			end
		end
	end

	// ============================================================
	// Source select and divider
	always_comb begin
		sel_agree = sync_r[ctl_r.channel_source_select][1] ==
			sync_r[ctl_r.channel_source_select][2];
		sel_s3 = sync_r[ctl_r.channel_source_select][2];
	end

	assign rise = sel_agree && sel_s3 && !lvl_r;
	assign bypass = ctl_r.channel_source_select == occ_pkg::OCC_SRC_PREF ||
		ctl_r.channel_source_select == occ_pkg::OCC_SRC_SREF;
	assign half = (9'({1'b0, div_r}) + 9'h002) >> 1;
	// A count left above a newly shrunk code wraps at once
	assign cnt_nxt = (cnt_r >= div_r) ? 8'h00 : cnt_r + 8'h01;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			lvl_r <= 1'b0;
		end else if (ce_i && sel_agree) begin
			lvl_r <= sel_s3;
		end
	end

	// Count source rising edges; wraps after code plus one of them
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			cnt_r <= 8'h00;
		end else if (ce_i && rise) begin
			cnt_r <= bypass ? 8'h00 : cnt_nxt;
		end
	end

	// Rebuilt channel clock; odd ratios run high one edge longer
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			clk_r <= 1'b0;
		end else if (ce_i) begin
			if (bypass || div_r == 8'h00) begin
				clk_r <= sel_agree ? sel_s3 : lvl_r;
			end else if (rise) begin
				clk_r <= {1'b0, cnt_nxt} < half;
			end else if (sel_agree && !sel_s3) begin
				clk_r <= clk_r;
			end
		end
	end

	// ============================================================
	// Driver decode
	function automatic occ_pkg::occ_leg_s leg_dec(input logic [1:0] m,
		input logic c);
		leg_dec.oe = m != occ_pkg::OCC_LEG_TRI;
		leg_dec.lvl = (m == occ_pkg::OCC_LEG_INV) ? !c :
			(m == occ_pkg::OCC_LEG_TRUE) ? c : 1'b0;
	endfunction : leg_dec

	always_comb begin
		leg_p = '0;
		leg_n = '0;
		tail_ma_o = 5'h00;
		load_ohm_o = 8'h00;
		case (ctl_r.fmt)
		occ_pkg::OCC_FMT_ACDIFF, occ_pkg::OCC_FMT_HCSL: begin
			leg_p = '{lvl: clk_r, oe: 1'b1};
			leg_n = '{lvl: !clk_r, oe: 1'b1};
			case (ctl_r.driver_mode_first)
			2'h0: tail_ma_o = `OCC_TAIL_4MA;
			2'h1: tail_ma_o = `OCC_TAIL_6MA;
			2'h2: tail_ma_o = `OCC_TAIL_8MA;
			default: tail_ma_o = (ctl_r.fmt == occ_pkg::OCC_FMT_HCSL) ?
				`OCC_TAIL_16MA : `OCC_TAIL_8MA;
			endcase
			if (ctl_r.fmt == occ_pkg::OCC_FMT_HCSL) begin
				case (ctl_r.driver_mode_second)
				2'h0: begin
					leg_p.oe = 1'b0;
					leg_n.oe = 1'b0;
				end
				2'h1: load_ohm_o = `OCC_LOAD_50;
				2'h2: load_ohm_o = `OCC_LOAD_100;
				default: load_ohm_o = `OCC_LOAD_200;
				endcase
			end
		end
		occ_pkg::OCC_FMT_CMOS: begin
			leg_p = leg_dec(ctl_r.driver_mode_first, clk_r);
			leg_n = leg_dec(ctl_r.driver_mode_second, clk_r);
		end
		default: begin
			leg_p = '0;
		end
		endcase
	end

	assign out_p_o = leg_p.lvl;
	assign out_p_oe_o = leg_p.oe;
	assign out_n_o = leg_n.lvl;
	assign out_n_oe_o = leg_n.oe;

	// ============================================================
	// Checks
	sequence s_ctl_wr;
		ce_i && wr_i && addr_i == `OCC_OFF_CTL;
	endsequence

	sequence s_late_nvm;
		ce_i && nvm_load_i && nvm_done_r && !wr_i;
	endsequence

	AST_SRC_BYPASS: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && ctl_r.channel_source_select == occ_pkg::OCC_SRC_PREF &&
		sync_r[2][1] == sync_r[2][2] |=> clk_r == $past(sync_r[2][2]))
		else $error("primary reference not passed through");
	AST_FMT_OFF: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ctl_r.fmt == occ_pkg::OCC_FMT_OFF |-> !out_p_oe_o && !out_n_oe_o)
		else $error("disabled output is driven");
	AST_CMOS_LOW: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ctl_r.fmt == occ_pkg::OCC_FMT_CMOS &&
		ctl_r.driver_mode_first == 2'h1 |-> out_p_oe_o && !out_p_o)
		else $error("held-low leg not low");
	AST_TAIL16: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ctl_r.fmt == occ_pkg::OCC_FMT_HCSL &&
		ctl_r.driver_mode_first == 2'h3 |-> tail_ma_o == `OCC_TAIL_16MA)
		else $error("HCSL code 3 tail not 16 mA");
	AST_LOAD: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ctl_r.fmt != occ_pkg::OCC_FMT_HCSL |-> load_ohm_o == 8'h00)
		else $error("load set outside HCSL");
	AST_DIV_WRAP: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && rise && !bypass && cnt_r == div_r |=> cnt_r == 8'h00)
		else $error("divider count did not wrap");
	AST_BYP_CNT: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && rise && bypass |=> cnt_r == 8'h00)
		else $error("divider ran on a reference");
	AST_SW_WR: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		s_ctl_wr ##1 s_late_nvm |=> ctl_r == $past(wdata_i, 2))
		else $error("late image overrode a software write");
	AST_SW_NVM: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		ce_i && wr_i && addr_i == `OCC_OFF_CTL && nvm_load_i
		|=> ctl_r == $past(wdata_i))
		else $error("same-cycle image beat a software write");

endmodule : occ_channel6

/* src/occ_consts.svh */
// Purpose: Offsets, field positions, reset values and codes of the
//          channel 6 output control block.
// Assumes: Registers are 8 bits wide on an 8-bit address.
// Notes:   Definitions only.
`ifndef OCC_CONSTS_SVH
`define OCC_CONSTS_SVH

// ============================================================
// Register offsets
`define OCC_OFF_CTL 8'h29
`define OCC_OFF_DIV 8'h2A
`define OCC_OFF_STAT 8'h2F

// ============================================================
// Field positions in the control register
`define OCC_SRC_MSB 7
`define OCC_SRC_LSB 6
`define OCC_FMT_MSB 5
`define OCC_FMT_LSB 4
`define OCC_M1_MSB 3
`define OCC_M1_LSB 2
`define OCC_M2_MSB 1
`define OCC_M2_LSB 0

// ============================================================
// Reset values
`define OCC_RST_SRC 2'h0
`define OCC_RST_FMT 2'h1
`define OCC_RST_M1 2'h2
`define OCC_RST_M2 2'h0
`define OCC_RST_DIV 8'h05

// ============================================================
// Tail current in mA and HCSL load in ohms
`define OCC_TAIL_4MA 5'h04
`define OCC_TAIL_6MA 5'h06
`define OCC_TAIL_8MA 5'h08
`define OCC_TAIL_16MA 5'h10
`define OCC_LOAD_50 8'h32
`define OCC_LOAD_100 8'h64
`define OCC_LOAD_200 8'hC8

// Synchroniser depth for the source clock pins
`define OCC_SYNC_DEPTH 3

`endif

/* src/occ_pkg.sv */
// Purpose: Types of the channel 6 output control block.
// Assumes: Constants live in occ_consts.svh.
// Notes:   Enum codes follow the register field encodings.
package occ_pkg;

	typedef enum logic [1:0] {
		OCC_SRC_SYN1 = 2'h0,
		OCC_SRC_SYN2 = 2'h1,
		OCC_SRC_PREF = 2'h2,
		OCC_SRC_SREF = 2'h3
	} occ_src_e;

	typedef enum logic [1:0] {
		OCC_FMT_OFF = 2'h0,
		OCC_FMT_ACDIFF = 2'h1,
		OCC_FMT_HCSL = 2'h2,
		OCC_FMT_CMOS = 2'h3
	} occ_fmt_e;

	// Leg behaviour in single-ended mode
	typedef enum logic [1:0] {
		OCC_LEG_TRI = 2'h0,
		OCC_LEG_LOW = 2'h1,
		OCC_LEG_INV = 2'h2,
		OCC_LEG_TRUE = 2'h3
	} occ_leg_e;

	typedef struct packed {
		occ_src_e channel_source_select;
		occ_fmt_e fmt;
		logic [1:0] driver_mode_first;
		logic [1:0] driver_mode_second;
	} occ_ctl_s;

	// One output leg: level and enable
	typedef struct packed {
		logic lvl;
		logic oe;
	} occ_leg_s;

endpackage : occ_pkg

/* test/occ_channel6_test.sv */
// Purpose: Self-checking bench for the channel 6 output control block.
// Assumes: Source clocks are slow square waves made from the core clock.
// Notes:   Bench drives every port itself; ce_i is held high except for one cycle in t_race.
`timescale 1ns/10ps
`include "occ_consts.svh"
module occ_channel6_test;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic [3:0] src_clk_i = 4'h0;
	logic nvm_load_i = 1'b0;
	logic [7:0] nvm_ctl_i = 8'h00;
	logic [7:0] nvm_div_i = 8'h00;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [7:0] load_ohm_o;
	logic [4:0] tail_ma_o;
	logic out_p_o;
	logic out_p_oe_o;
	logic out_n_o;
	logic out_n_oe_o;
	logic src_tog = 1'b0;
	logic [3:0] src_lvl = 4'h0;
	int cyc = 0;
	int err_total = 0;
	int tests_run = 0;

	occ_channel6 u_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.ce_i(ce_i), .src_clk_i(src_clk_i), .nvm_load_i(nvm_load_i),
		.nvm_ctl_i(nvm_ctl_i), .nvm_div_i(nvm_div_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.out_p_o(out_p_o), .out_p_oe_o(out_p_oe_o), .out_n_o(out_n_o),
		.out_n_oe_o(out_n_oe_o), .tail_ma_o(tail_ma_o),
		.load_ohm_o(load_ohm_o));

	always #5 core_clk_i = ~core_clk_i;

	// ============================================================
	// Source clocks: period of 16 core cycles keeps them rebuildable
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		src_clk_i <= src_tog ? {4{cyc[3]}} : src_lvl;
		if (cyc == 60000) begin
			err_total++;
			give_verdict();
		end
	end

	// ============================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", e, rdata_o);
	endtask : rchk

	task automatic nvm(input logic [7:0] c, input logic [7:0] d);
		@(posedge core_clk_i);
		nvm_ctl_i <= c;
		nvm_div_i <= d;
		nvm_load_i <= 1'b1;
		@(posedge core_clk_i);
		nvm_load_i <= 1'b0;
	endtask : nvm

	task automatic edge_wait(input logic v, inout int n);
		for (int k = 0; k < 9000 && out_p_o !== v; k++) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
	endtask : edge_wait

	// ============================================================
	// Scenarios
	task automatic t_reset();
		chk("tail", `OCC_TAIL_8MA, {3'h0, tail_ma_o});
		rchk(`OCC_OFF_CTL, 8'h18);
		rchk(`OCC_OFF_DIV, `OCC_RST_DIV);
		@(posedge core_clk_i);
		#1 chk("rdata idle", 8'h00, rdata_o);
		wr(8'h30, 8'hFF);
		rchk(8'h30, 8'h00);
		rchk(`OCC_OFF_CTL, 8'h18);
	endtask : t_reset

	task automatic t_nvm();
		nvm(8'h9E, 8'h11);
		rchk(`OCC_OFF_CTL, 8'h9E);
		rchk(`OCC_OFF_DIV, 8'h11);
		nvm(8'h00, 8'h00);
		rchk(`OCC_OFF_CTL, 8'h9E);
		wr(`OCC_OFF_DIV, 8'h00);
		rchk(`OCC_OFF_DIV, 8'h00);
	endtask : t_nvm

	task automatic t_decode();
		logic pe, ne, pl, nl;
		logic [7:0] tl, ld;
		src_lvl <= 4'h4;
		for (int f = 0; f < 4; f++)
			for (int a = 0; a < 4; a++)
				for (int b = 0; b < 4; b++) begin
					wr(`OCC_OFF_CTL, {2'h2, f[1:0], a[1:0], b[1:0]});
					repeat (8) @(posedge core_clk_i);
					#1;
					pe = f == 1 || (f == 2 && b != 0) || (f == 3 && a != 0);
					ne = f == 1 || (f == 2 && b != 0) || (f == 3 && b != 0);
					pl = f == 3 ? (a == 3) : 1'b1;
					nl = f == 3 ? (b == 3) : 1'b0;
					tl = a == 0 ? `OCC_TAIL_4MA : a == 1 ? `OCC_TAIL_6MA :
						(a == 3 && f == 2) ? `OCC_TAIL_16MA : `OCC_TAIL_8MA;
					tl = (f == 1 || f == 2) ? tl : 8'h00;
					ld = b == 1 ? `OCC_LOAD_50 : b == 2 ? `OCC_LOAD_100 :
						b == 3 ? `OCC_LOAD_200 : 8'h00;
					chk("tail", tl, {3'h0, tail_ma_o});
					chk("load", f == 2 ? ld : 8'h00, load_ohm_o);
					chk("p_oe", pe, out_p_oe_o);
					chk("n_oe", ne, out_n_oe_o);
					if (pe) chk("p_lvl", pl, out_p_o);
					if (ne) chk("n_lvl", nl, out_n_o);
				end
	endtask : t_decode

	task automatic t_mux();
		for (int s = 0; s < 4; s++) begin
			wr(`OCC_OFF_CTL, {s[1:0], 6'h18});
			src_lvl <= 4'h1 << s;
			repeat (8) @(posedge core_clk_i);
			#1 chk("sel high", 8'h01, {7'h0, out_p_o});
			src_lvl <= ~(4'h1 << s);
			repeat (8) @(posedge core_clk_i);
			#1 chk("sel low", 8'h00, {7'h0, out_p_o});
		end
	endtask : t_mux

	// Mid-run reset: a write beats a same-cycle image, a late image is
	// ignored, and a write under a low clock enable is lost
	task automatic t_race();
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		addr_i <= `OCC_OFF_CTL;
		wdata_i <= 8'h5C;
		wr_i <= 1'b1;
		nvm_ctl_i <= 8'hE3;
		nvm_div_i <= 8'h21;
		nvm_load_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		nvm_load_i <= 1'b0;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		wdata_i <= 8'h9B;
		wr_i <= 1'b1;
		#1 chk("rdata", 8'h5C, rdata_o);
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		nvm_load_i <= 1'b1;
		@(posedge core_clk_i);
		nvm_load_i <= 1'b0;
		rchk(`OCC_OFF_CTL, 8'h9B);
		rchk(`OCC_OFF_DIV, 8'h21);
		rchk(`OCC_OFF_STAT, 8'h05);
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		addr_i <= `OCC_OFF_CTL;
		wdata_i <= 8'h00;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		wr_i <= 1'b0;
		rchk(`OCC_OFF_CTL, 8'h9B);
	endtask : t_race

	task automatic t_div(input logic [7:0] c, input logic [7:0] d,
		input int e);
		int n;
		wr(`OCC_OFF_CTL, c);
		wr(`OCC_OFF_DIV, d);
		n = 0;
		edge_wait(1'b0, n);
		edge_wait(1'b1, n);
		n = 0;
		edge_wait(1'b0, n);
		edge_wait(1'b1, n);
		tests_run++;
		if (n != e) begin
			err_total++;
			$display("ERROR period expected %0d seen %0d", e, n);
		end
	endtask : t_div

	task automatic give_verdict();
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// ============================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		#1;
		t_reset();
		t_nvm();
		t_decode();
		t_mux();
		t_race();
		src_tog <= 1'b1;
		t_div(8'h18, 8'h00, 16);
		t_div(8'h18, 8'h01, 32);
		t_div(8'h58, 8'h02, 48);
		t_div(8'h18, 8'hFF, 4096);
		t_div(8'h98, 8'h02, 16);
		t_div(8'hD8, 8'h02, 16);
		give_verdict();
	end
endmodule : occ_channel6_test
